// ---- rtl/slric_top.sv ----
// supply sequencing, safe state, periodic interrupt and pin interrupt
// assumes supply comparator levels and clock ticks synchronous to clk;
// arst_n is the power-on reset
`timescale 1ns/10ps
`include "slric_defs.svh"

module slric_top (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  input  wire logic       supply_below_por,
  input  wire logic       supply_below_lvd,
  input  wire logic       supply_below_lvw,
  input  wire logic       supply_below_rearm,
  input  wire logic       other_reset_req,
  input  wire logic       stop_exec,
  input  wire logic [2:0] power_mode,
  input  wire logic       ext_clk_tick,
  input  wire logic       int_clk_tick,
  input  wire logic       irq_pin,
  output logic            chip_reset_hold,
  output logic            lvd_irq,
  output logic            rti_irq,
  output logic            pin_irq,
  output logic            wakeup_req,
  output logic            safe_state_active,
  output logic            pull_enable,
  output logic            pull_down_select
);

  slric_pkg::slric_seq_t state;
  slric_pkg::slric_seq_t next_state;

  logic                        undervoltage_reset_enable;
  logic                        undervoltage_reset_enable_written;
  logic                        undervoltage_interrupt_enable;
  logic                        safe_bit;
  logic                        undervoltage_detect_flag;
  logic                        supply_warning_flag;
  logic                        por_status;
  logic                        lvd_status;
  logic                        pin_edge_polarity_select;
  logic                        pin_function_enable;
  logic                        pin_event_flag;
  logic                        pin_event_interrupt_enable;
  logic                        pin_detect_level_mode;
  logic [2:0]                  periodic_interval_select;
  logic                        periodic_interrupt_enable;
  logic                        rti_clk_internal;
  logic                        rti_flag;
  logic [`SLRIC_RTI_CNT_W-1:0] rti_count;
  logic                        blocked;
  logic                        soft_rst;
  logic                        lvd_rst_take;
  logic                        oth_rst_take;
  logic                        wr_pin;
  logic                        wr_pm1;
  logic                        wr_rti;
  logic                        rti_tick;
  logic                        rti_wrap;
  logic                        edge_seen;
  logic                        level_active;
  logic                        pin_hold;
  logic [7:0]                  next_rd_data;

  ////////////////////////////////////////////////////////////////////////
  // terminal count of the periodic divider for an interval code
  function automatic logic [`SLRIC_RTI_CNT_W-1:0] rti_term(
    input logic [2:0] sel
  );
    case (sel)
      3'h1:    rti_term = `SLRIC_RTI_P1;
      3'h2:    rti_term = `SLRIC_RTI_P2;
      3'h3:    rti_term = `SLRIC_RTI_P3;
      3'h4:    rti_term = `SLRIC_RTI_P4;
      3'h5:    rti_term = `SLRIC_RTI_P5;
      3'h6:    rti_term = `SLRIC_RTI_P6;
      default: rti_term = `SLRIC_RTI_P7;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decode and common terms
  always_comb begin
    wr_pin       = wr_en & (addr == `SLRIC_OFS_PIN);
    wr_pm1       = wr_en & (addr == `SLRIC_OFS_PM1);
    wr_rti       = wr_en & (addr == `SLRIC_OFS_RTI);
    // above rearm the safe bit blocks nothing; it still gates entry to the safe state
    blocked      = safe_bit & supply_below_rearm;
    lvd_rst_take = (state == slric_pkg::SLRIC_SEQ_RUN) & ~blocked &
                   supply_below_lvd & undervoltage_reset_enable;
    oth_rst_take = (state == slric_pkg::SLRIC_SEQ_RUN) & ~blocked &
                   other_reset_req;
    soft_rst     = (state == slric_pkg::SLRIC_SEQ_HOLD) | supply_below_por;
  end

  ////////////////////////////////////////////////////////////////////////
  // reset sequencer
  always_comb begin
    next_state = state;
    case (state)
      slric_pkg::SLRIC_SEQ_HOLD: begin
        if (!supply_below_por && !supply_below_lvd) begin
          next_state = slric_pkg::SLRIC_SEQ_RUN;
        end
      end
      slric_pkg::SLRIC_SEQ_RUN: begin
        if (supply_below_por || lvd_rst_take || oth_rst_take) begin
          next_state = slric_pkg::SLRIC_SEQ_HOLD;
        end else if (stop_exec && safe_bit &&
                     undervoltage_detect_flag) begin
          next_state = slric_pkg::SLRIC_SEQ_SAFE;
        end
      end
      slric_pkg::SLRIC_SEQ_SAFE: begin
        // power-on reset cannot be blocked, the supply really collapsed
        if (supply_below_por) begin
          next_state = slric_pkg::SLRIC_SEQ_HOLD;
        end else if (!supply_below_rearm) begin
          next_state = slric_pkg::SLRIC_SEQ_RUN;
        end
      end
      default: next_state = slric_pkg::SLRIC_SEQ_HOLD;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= slric_pkg::SLRIC_SEQ_HOLD;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset cause status
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      por_status <= 1'b1;
      lvd_status <= 1'b1;
    end else if (supply_below_por) begin
      por_status <= 1'b1;
      lvd_status <= 1'b1;
    end else if (lvd_rst_take) begin
      lvd_status <= 1'b1;
    end else if (oth_rst_take) begin
      por_status <= 1'b0;
      lvd_status <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write-once reset enable, survives every reset but power-on
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      undervoltage_reset_enable <= 1'b1;
      undervoltage_reset_enable_written             <= 1'b0;
    end else if (supply_below_por) begin
      undervoltage_reset_enable <= 1'b1;
      undervoltage_reset_enable_written             <= 1'b0;
    end else if (wr_pm1 && !undervoltage_reset_enable_written) begin
      undervoltage_reset_enable <= wr_data[`SLRIC_PM1_UNDERVOLTAGE_RESET_ENABLE];
      undervoltage_reset_enable_written             <= 1'b1;
    end
  end

  // safe bit and interrupt enable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      undervoltage_interrupt_enable <= 1'b0;
      safe_bit                      <= 1'b0;
    end else if (soft_rst) begin
      undervoltage_interrupt_enable <= 1'b0;
      safe_bit                      <= 1'b0;
    end else if (wr_pm1) begin
      undervoltage_interrupt_enable <= wr_data[`SLRIC_PM1_UNDERVOLTAGE_INTERRUPT_ENABLE];
      safe_bit <= wr_data[`SLRIC_PM1_SAFE] &
                  ~undervoltage_reset_enable;
    end
  end

  // detect flag: a detect in the acknowledge cycle wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      undervoltage_detect_flag <= 1'b0;
    end else if (supply_below_lvd) begin
      undervoltage_detect_flag <= 1'b1;
    end else if (soft_rst) begin
      undervoltage_detect_flag <= 1'b0;
    end else if (wr_pm1 && wr_data[`SLRIC_PM1_ACK]) begin
      undervoltage_detect_flag <= 1'b0;
    end
  end

  // warning flag follows the comparator, no request attached
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      supply_warning_flag <= 1'b0;
    end else begin
      supply_warning_flag <= supply_below_lvw;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // periodic interrupt control
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      periodic_interval_select  <= 3'h0;
      periodic_interrupt_enable <= 1'b0;
      rti_clk_internal          <= 1'b0;
    end else if (soft_rst) begin
      periodic_interval_select  <= 3'h0;
      periodic_interrupt_enable <= 1'b0;
      rti_clk_internal          <= 1'b0;
    end else if (wr_rti) begin
      periodic_interval_select <=
        wr_data[`SLRIC_RTI_SEL_HI:`SLRIC_RTI_SEL_LO];
      periodic_interrupt_enable <= wr_data[`SLRIC_RTI_IE];
      rti_clk_internal          <= wr_data[`SLRIC_RTI_CLKSEL];
    end
  end

  // source per mode; software must keep the oscillator alive in stop3
  always_comb begin
    case (power_mode)
      `SLRIC_MODE_RUN,
      `SLRIC_MODE_WAIT:  rti_tick = ext_clk_tick;
      `SLRIC_MODE_STOP2: rti_tick = int_clk_tick;
      `SLRIC_MODE_STOP3: rti_tick = rti_clk_internal ? int_clk_tick
                                                     : ext_clk_tick;
      default:           rti_tick = 1'b0;
    endcase
    rti_wrap = rti_tick & (periodic_interval_select != 3'h0) &
               (rti_count == rti_term(periodic_interval_select));
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rti_count <= '0;
    end else if (periodic_interval_select == 3'h0 || rti_wrap) begin
      rti_count <= '0;
    end else if (rti_tick) begin
      rti_count <= rti_count + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rti_flag <= 1'b0;
    end else if (rti_wrap) begin
      rti_flag <= 1'b1;
    end else if (soft_rst) begin
      rti_flag <= 1'b0;
    end else if (wr_rti && wr_data[`SLRIC_RTI_ACK]) begin
      rti_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt pin
  slric_pin_detect u_pin (
    .clk                      (clk),
    .arst_n                   (arst_n),
    .pin_raw                  (irq_pin),
    .pin_function_enable      (pin_function_enable),
    .pin_edge_polarity_select (pin_edge_polarity_select),
    .edge_seen                (edge_seen),
    .level_active             (level_active)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_edge_polarity_select   <= 1'b0;
      pin_function_enable        <= 1'b0;
      pin_event_interrupt_enable <= 1'b0;
      pin_detect_level_mode      <= 1'b0;
    end else if (soft_rst) begin
      pin_edge_polarity_select   <= 1'b0;
      pin_function_enable        <= 1'b0;
      pin_event_interrupt_enable <= 1'b0;
      pin_detect_level_mode      <= 1'b0;
    end else if (wr_pin) begin
      pin_edge_polarity_select   <= wr_data[`SLRIC_PIN_EDG];
      pin_function_enable        <= wr_data[`SLRIC_PIN_PE];
      pin_event_interrupt_enable <= wr_data[`SLRIC_PIN_IE];
      pin_detect_level_mode      <= wr_data[`SLRIC_PIN_MOD];
    end
  end

  // in level mode an asserted pin keeps setting the flag
  always_comb begin
    pin_hold = pin_detect_level_mode & level_active;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_event_flag <= 1'b0;
    end else if (edge_seen || pin_hold) begin
      pin_event_flag <= 1'b1;
    end else if (soft_rst) begin
      pin_event_flag <= 1'b0;
    end else if (wr_pin && wr_data[`SLRIC_PIN_ACK]) begin
      pin_event_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lvd_irq <= 1'b0;
      rti_irq <= 1'b0;
      pin_irq <= 1'b0;
    end else begin
      lvd_irq <= undervoltage_detect_flag & undervoltage_interrupt_enable &
                 ~undervoltage_reset_enable & ~blocked &
                 ~soft_rst;
      rti_irq <= rti_flag & periodic_interrupt_enable & ~blocked &
                 ~soft_rst;
      pin_irq <= pin_event_flag & pin_event_interrupt_enable & ~blocked &
                 ~soft_rst;
    end
  end

  // wakeup from stop on any enabled request, unless blocked
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wakeup_req <= 1'b0;
    end else begin
      wakeup_req <= ~blocked & ~soft_rst &
                    (power_mode != `SLRIC_MODE_RUN) &
                    (power_mode != `SLRIC_MODE_WAIT) &
                    ((rti_flag & periodic_interrupt_enable) |
                     (pin_event_flag & pin_event_interrupt_enable) |
                     (undervoltage_detect_flag &
                      undervoltage_interrupt_enable &
                      ~undervoltage_reset_enable));
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chip_reset_hold   <= 1'b1;
      safe_state_active <= 1'b0;
    end else begin
      chip_reset_hold   <= (next_state == slric_pkg::SLRIC_SEQ_HOLD);
      safe_state_active <= (next_state == slric_pkg::SLRIC_SEQ_SAFE);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pull_enable      <= 1'b0;
      pull_down_select <= 1'b0;
    end else begin
      pull_enable      <= pin_function_enable;
      pull_down_select <= pin_function_enable &
                          pin_edge_polarity_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port; acknowledge and unused bits read zero
  always_comb begin
    next_rd_data = `SLRIC_ZERO8;
    case (addr)
      `SLRIC_OFS_PIN: begin
        next_rd_data[`SLRIC_PIN_EDG]  = pin_edge_polarity_select;
        next_rd_data[`SLRIC_PIN_PE]   = pin_function_enable;
        next_rd_data[`SLRIC_PIN_FLAG] = pin_event_flag;
        next_rd_data[`SLRIC_PIN_IE]   = pin_event_interrupt_enable;
        next_rd_data[`SLRIC_PIN_MOD]  = pin_detect_level_mode;
      end
      `SLRIC_OFS_PM1: begin
        next_rd_data[`SLRIC_PM1_UNDERVOLTAGE_RESET_ENABLE] = undervoltage_reset_enable;
        next_rd_data[`SLRIC_PM1_UNDERVOLTAGE_INTERRUPT_ENABLE] = undervoltage_interrupt_enable;
        next_rd_data[`SLRIC_PM1_SAFE]  = safe_bit;
        next_rd_data[`SLRIC_PM1_UNDERVOLTAGE_DETECT_FLAG]  = undervoltage_detect_flag;
      end
      `SLRIC_OFS_PM2: begin
        next_rd_data[`SLRIC_PM2_SUPPLY_WARNING_FLAG] = supply_warning_flag;
      end
      `SLRIC_OFS_RTI: begin
        next_rd_data[`SLRIC_RTI_SEL_HI:`SLRIC_RTI_SEL_LO] =
          periodic_interval_select;
        next_rd_data[`SLRIC_RTI_IE]     = periodic_interrupt_enable;
        next_rd_data[`SLRIC_RTI_CLKSEL] = rti_clk_internal;
        next_rd_data[`SLRIC_RTI_FLAG]   = rti_flag;
      end
      `SLRIC_OFS_RST: begin
        next_rd_data[`SLRIC_RST_POR] = por_status;
        next_rd_data[`SLRIC_RST_LVD] = lvd_status;
      end
      default: next_rd_data = `SLRIC_ZERO8;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= `SLRIC_ZERO8;
    end else if (rd_en) begin
      rd_data <= next_rd_data;
    end else begin
      rd_data <= `SLRIC_ZERO8;
    end
  end

endmodule

// ---- rtl/slric_defs.svh ----
// constants of the low-voltage, periodic interrupt and pin interrupt block
// assumes an 8-bit register port with byte-wide offsets
`ifndef SLRIC_DEFS_SVH
`define SLRIC_DEFS_SVH

// register offsets
`define SLRIC_OFS_PIN        8'h00
`define SLRIC_OFS_PM1        8'h01
`define SLRIC_OFS_PM2        8'h02
`define SLRIC_OFS_RTI        8'h03
`define SLRIC_OFS_RST        8'h04

// pin_interrupt_status_control fields
`define SLRIC_PIN_EDG        5
`define SLRIC_PIN_PE         4
`define SLRIC_PIN_FLAG       3
`define SLRIC_PIN_ACK        2
`define SLRIC_PIN_IE         1
`define SLRIC_PIN_MOD        0

// power_mgmt_control_one fields
`define SLRIC_PM1_UNDERVOLTAGE_RESET_ENABLE      0
`define SLRIC_PM1_UNDERVOLTAGE_INTERRUPT_ENABLE      1
`define SLRIC_PM1_SAFE       2
`define SLRIC_PM1_UNDERVOLTAGE_DETECT_FLAG       3
`define SLRIC_PM1_ACK        4

// power_mgmt_control_two fields
`define SLRIC_PM2_SUPPLY_WARNING_FLAG       0

// periodic_interrupt_control fields
`define SLRIC_RTI_SEL_HI     2
`define SLRIC_RTI_SEL_LO     0
`define SLRIC_RTI_IE         4
`define SLRIC_RTI_CLKSEL     5
`define SLRIC_RTI_ACK        6
`define SLRIC_RTI_FLAG       7

// reset_cause_status fields
`define SLRIC_RST_POR        7
`define SLRIC_RST_LVD        1

// power mode encodings on power_mode
`define SLRIC_MODE_RUN       3'h0
`define SLRIC_MODE_WAIT      3'h1
`define SLRIC_MODE_STOP1     3'h2
`define SLRIC_MODE_STOP2     3'h3
`define SLRIC_MODE_STOP3     3'h4

// periodic interval terminal counts, in source clock ticks
`define SLRIC_RTI_CNT_W      10
`define SLRIC_RTI_P1         10'h007
`define SLRIC_RTI_P2         10'h01F
`define SLRIC_RTI_P3         10'h03F
`define SLRIC_RTI_P4         10'h07F
`define SLRIC_RTI_P5         10'h0FF
`define SLRIC_RTI_P6         10'h1FF
`define SLRIC_RTI_P7         10'h3FF

`define SLRIC_ZERO8          8'h00

`endif

// ---- rtl/slric_pkg.sv ----
// types of the low-voltage, periodic interrupt and pin interrupt block
// assumes nothing beyond the header of constants
package slric_pkg;

  // reset sequencer states, one-hot
  typedef enum logic [2:0] {
    SLRIC_SEQ_HOLD = 3'h1,
    SLRIC_SEQ_RUN  = 3'h2,
    SLRIC_SEQ_SAFE = 3'h4
  } slric_seq_t;

endpackage

// ---- rtl/slric_pin_detect.sv ----
// interrupt pin synchroniser and edge/level detector
// assumes the pin is asynchronous to clk; outputs are clk synchronous
`timescale 1ns/10ps

module slric_pin_detect (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic pin_raw,
  input  wire logic pin_function_enable,
  input  wire logic pin_edge_polarity_select,
  output logic      edge_seen,
  output logic      level_active
);

  logic sync_a;
  logic sync_b;
  logic pin_prev;
  logic pin_act;

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser; sync_a feeds only sync_b
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // asserted level: high when rising selected, low when falling selected
  always_comb begin
    pin_act = pin_function_enable &
              (sync_b ~^ pin_edge_polarity_select);
  end

  // pin_prev also starts low after enable, so an already asserted pin
  // counts as an edge; an honest trade against missing one
  always_comb begin
    edge_seen    = pin_act & ~pin_prev;
    level_active = pin_act;
  end

endmodule

// ---- testbench/slric_chk.sv ----
// assertions on the ports of slric_top
// assumes one clock domain with arst_n as its reset
`timescale 1ns/10ps

module slric_chk (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       rd_en,
  input wire logic [7:0] rd_data,
  input wire logic       supply_below_por,
  input wire logic       supply_below_lvd,
  input wire logic       supply_below_rearm,
  input wire logic       other_reset_req,
  input wire logic       chip_reset_hold,
  input wire logic       lvd_irq,
  input wire logic       rti_irq,
  input wire logic       pin_irq,
  input wire logic       wakeup_req,
  input wire logic       safe_state_active,
  input wire logic       pull_enable,
  input wire logic       pull_down_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  por_hold_a: assert property (supply_below_por |=> chip_reset_hold)
    else $error("no hold after power-on");
  lvd_hold_a: assert property (chip_reset_hold && supply_below_lvd
    |=> chip_reset_hold) else $error("hold left below detect");
  hold_exit_a: assert property (chip_reset_hold && !supply_below_por
    && !supply_below_lvd && !other_reset_req |=> !chip_reset_hold)
    else $error("hold kept with good supply");
  safe_block_a: assert property (safe_state_active && supply_below_rearm
    && $past(supply_below_rearm) |-> !(lvd_irq || rti_irq || pin_irq
    || wakeup_req)) else $error("request while blocked");
  safe_exit_a: assert property (safe_state_active && !supply_below_rearm
    |=> !safe_state_active) else $error("safe kept after rearm");
  state_one_a: assert property (!(safe_state_active && chip_reset_hold))
    else $error("safe and hold together");
  pull_dir_a: assert property (pull_down_select |-> pull_enable)
    else $error("pull-down without pin enable");
  rd_idle_a: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data outside read slot");
endmodule

bind slric_top slric_chk u_chk (.*);

// ---- testbench/slric_pin_model.sv ----
// external interrupt pin with its pull resistor
// assumes the block reports the pull state it asks for
`timescale 1ns/10ps

module slric_pin_model (
  input  wire logic clk,
  input  wire logic drive_en,
  input  wire logic drive_lvl,
  input  wire logic pull_enable,
  input  wire logic pull_down_select,
  output logic      pin
);
  initial pin = 1'b1;
  // an unpulled released pin toggles so a stale level never looks driven
  always @(posedge clk) begin
    if (drive_en)
      pin <= drive_lvl;
    else if (pull_enable)
      pin <= !pull_down_select;
    else
      pin <= !pin;
  end
endmodule

// ---- testbench/slric_top_tb_top.sv ----
// self-checking bench of slric_top
// assumes the bound checker and the pin model beside the block
`timescale 1ns/10ps
`include "slric_defs.svh"

module slric_top_tb_top;
  logic       clk, arst_n, wr_en, rd_en, por, undervoltage_detect, supply_warning, rearm, oth, stp;
  logic       ext_t, int_t, drv_en, drv_lvl, pin, hold, lvd_irq, rti_irq;
  logic       pin_irq, wake, safe, pull_en, pull_dn;
  logic [7:0] addr, wdat, rdat;
  logic [2:0] mode;
  int         err_total, cmp_count;

  slric_top u_dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wr_data(wdat),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rdat), .supply_below_por(por),
    .supply_below_lvd(undervoltage_detect), .supply_below_lvw(supply_warning),
    .supply_below_rearm(rearm), .other_reset_req(oth), .stop_exec(stp),
    .power_mode(mode), .ext_clk_tick(ext_t), .int_clk_tick(int_t),
    .irq_pin(pin), .chip_reset_hold(hold), .lvd_irq(lvd_irq),
    .rti_irq(rti_irq), .pin_irq(pin_irq), .wakeup_req(wake),
    .safe_state_active(safe), .pull_enable(pull_en),
    .pull_down_select(pull_dn));
  slric_pin_model u_pin (.clk(clk), .drive_en(drv_en), .drive_lvl(drv_lvl),
    .pull_enable(pull_en), .pull_down_select(pull_dn), .pin(pin));

  //////////////////////////////////////////////////////////////////////////
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdat  <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 cmp8(rdat, exp);
  endtask
  // ticks spaced two cycles apart, either periodic source
  task automatic tick(input logic use_int, input int n);
    repeat (n) begin
      @(posedge clk);
      ext_t <= !use_int;
      int_t <= use_int;
      @(posedge clk);
      ext_t <= 1'b0;
      int_t <= 1'b0;
    end
  endtask
  task automatic pulse_stop_other();
    @(posedge clk);
    stp <= 1'b1;
    @(posedge clk);
    stp <= 1'b0;
    oth <= 1'b1;
    @(posedge clk);
    oth <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_por();
    cmp1(hold, 1'b0);
    rd(`SLRIC_OFS_RST, 8'h82);
    wr(`SLRIC_OFS_PM1, 8'h05);
    rd(`SLRIC_OFS_PM1, 8'h01);
    wr(`SLRIC_OFS_PM1, 8'h02);
    rd(`SLRIC_OFS_PM1, 8'h03);
    rd(8'h10, 8'h00);
  endtask
  task automatic t_lvd_reset();
    @(posedge clk);
    undervoltage_detect <= 1'b1;
    cyc(3);
    cmp1(hold, 1'b1);
    @(posedge clk);
    undervoltage_detect <= 1'b0;
    cyc(2);
    cmp1(hold, 1'b0);
    rd(`SLRIC_OFS_RST, 8'h82);
  endtask
  task automatic t_lvd_safe();
    @(posedge clk);
    por <= 1'b1;
    @(posedge clk);
    por <= 1'b0;
    cyc(2);
    rd(`SLRIC_OFS_RST, 8'h82);
    wr(`SLRIC_OFS_PM1, 8'h02);
    @(posedge clk);
    undervoltage_detect <= 1'b1;
    cyc(4);
    cmp1(lvd_irq, 1'b1);
    rd(`SLRIC_OFS_PM1, 8'h0A);
    wr(`SLRIC_OFS_PM1, 8'h06);
    rearm <= 1'b1;
    mode  <= `SLRIC_MODE_STOP3;
    cyc(3);
    cmp1(lvd_irq, 1'b0);
    pulse_stop_other();
    cyc(2);
    cmp1(safe, 1'b1);
    cmp1(hold, 1'b0);
    cmp1(wake, 1'b0);
    @(posedge clk);
    rearm <= 1'b0;
    undervoltage_detect   <= 1'b0;
    cyc(3);
    cmp1(safe, 1'b0);
    cmp1(wake, 1'b1);
    rd(`SLRIC_OFS_PM1, 8'h0E);
    @(posedge clk);
    mode <= `SLRIC_MODE_RUN;
    wr(`SLRIC_OFS_PM1, 8'h12);
    supply_warning <= 1'b1;
    cyc(3);
    rd(`SLRIC_OFS_PM1, 8'h02);
    rd(`SLRIC_OFS_PM2, 8'h01);
    cmp1(lvd_irq, 1'b0);
  endtask
  task automatic t_pin();
    wr(`SLRIC_OFS_PIN, 8'h12);
    cyc(2);
    cmp1(pull_en, 1'b1);
    cmp1(pull_dn, 1'b0);
    drv_lvl <= 1'b0;
    cyc(6);
    cmp1(pin_irq, 1'b1);
    rd(`SLRIC_OFS_PIN, 8'h1A);
    wr(`SLRIC_OFS_PIN, 8'h16);
    rd(`SLRIC_OFS_PIN, 8'h12);
    wr(`SLRIC_OFS_PIN, 8'h15);
    cyc(4);
    rd(`SLRIC_OFS_PIN, 8'h19);
    cmp1(pin_irq, 1'b0);
    drv_en <= 1'b0;
    cyc(5);
    wr(`SLRIC_OFS_PIN, 8'h15);
    rd(`SLRIC_OFS_PIN, 8'h11);
    wr(`SLRIC_OFS_PIN, 8'h30);
    cyc(6);
    cmp1(pull_dn, 1'b1);
    // a polarity change on a high pin counts as an edge; clear it
    wr(`SLRIC_OFS_PIN, 8'h34);
    rd(`SLRIC_OFS_PIN, 8'h30);
    drv_en  <= 1'b1;
    drv_lvl <= 1'b1;
    cyc(6);
    rd(`SLRIC_OFS_PIN, 8'h38);
    wr(`SLRIC_OFS_PIN, 8'hC4);
    cyc(2);
    rd(`SLRIC_OFS_PIN, 8'h00);
    cmp1(pull_en, 1'b0);
  endtask
  task automatic t_rti();
    wr(`SLRIC_OFS_RTI, 8'h11);
    mode <= `SLRIC_MODE_WAIT;
    tick(1'b0, 7);
    cyc(3);
    cmp1(rti_irq, 1'b0);
    tick(1'b0, 1);
    cyc(3);
    cmp1(rti_irq, 1'b1);
    wr(`SLRIC_OFS_RTI, 8'h01);
    cyc(2);
    cmp1(rti_irq, 1'b0);
    rd(`SLRIC_OFS_RTI, 8'h81);
    wr(`SLRIC_OFS_RTI, 8'h41);
    mode <= `SLRIC_MODE_STOP2;
    tick(1'b0, 8);
    rd(`SLRIC_OFS_RTI, 8'h01);
    tick(1'b1, 8);
    cyc(2);
    rd(`SLRIC_OFS_RTI, 8'h81);
    wr(`SLRIC_OFS_RTI, 8'h41);
    mode <= `SLRIC_MODE_STOP3;
    // oscillator kept running in stop3, so external ticks keep coming
    tick(1'b0, 8);
    cyc(2);
    rd(`SLRIC_OFS_RTI, 8'h81);
    wr(`SLRIC_OFS_RTI, 8'h41);
    mode <= `SLRIC_MODE_STOP1;
    tick(1'b0, 8);
    tick(1'b1, 8);
    rd(`SLRIC_OFS_RTI, 8'h01);
    wr(`SLRIC_OFS_RTI, 8'h40);
    tick(1'b1, 16);
    rd(`SLRIC_OFS_RTI, 8'h00);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  // whole run is a few hundred cycles
  initial begin
    #100us;
    err_total++;
    results();
  end
  initial begin
    {arst_n, wr_en, rd_en, por, undervoltage_detect, supply_warning, rearm, oth, stp} = '0;
    {ext_t, int_t, addr, wdat, mode} = '0;
    {drv_en, drv_lvl} = 2'b11;
    err_total = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    cyc(3);
    t_por();
    t_lvd_reset();
    t_lvd_safe();
    t_pin();
    t_rti();
    results();
  end
endmodule
